// [design/srr_exec.v]
/*
  Execution of the subroutine return and rotate-left-through-carry
  instructions inside the core.
  Assumes the fetch/decode stage presents one instruction with a one-cycle
  valid strobe, the return stack presents its top value combinationally,
  and data memory answers a read address in the same cycle.
  Flags other than C, N and Z ride through a rotate unchanged.
  The program counter latches sit outside and a return leaves them.
  The write port is registered, so memory must forward a pending write.
*/
// Operation
// - Return pops stack into program counter
// - Fast return restores working, flags, bank
// - Normal return leaves those registers alone
// - Rotate left through carry, msb to carry
// - Destination bit picks working or file
// - Access bit picks access or selected bank
// - Extended set: low offsets become indexed
`include "srr_exec_map.vh"

module srr_exec #(
  parameter PC_W = 21
) (
  input  wire            sys_clk_i,
  input  wire            rst_n_i,
  input  wire            instr_valid_i,
  input  wire [15:0]     instr_i,
  input  wire            ext_set_en_i,
  input  wire [PC_W-1:0] stack_top_value_i,
  input  wire [7:0]      shadow_working_reg_i,
  input  wire [7:0]      shadow_flag_reg_i,
  input  wire [3:0]      shadow_bank_select_i,
  input  wire [7:0]      fsr2_base_i,
  input  wire [7:0]      mem_rdata_i,
  output reg  [11:0]     mem_raddr_o,
  output reg  [11:0]     mem_waddr_o,
  output reg  [7:0]      mem_wdata_o,
  output reg             mem_we_o,
  output reg             stack_pop_o,
  output reg             pc_load_o,
  output reg  [PC_W-1:0] pc_o,
  output reg  [7:0]      working_reg_o,
  output reg  [7:0]      flag_reg_o,
  output reg  [3:0]      bank_select_reg_o,
  output reg             busy_o
);

  // ------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------
  function is_ret;
    input [15:0] w;
    begin
      is_ret = ((w & `SRR_RET_MASK) == `SRR_RET_OPC);
    end
  endfunction

  function is_rot;
    input [15:0] w;
    begin
      is_rot = (w[`SRR_ROT_OPC_HI:`SRR_ROT_OPC_LO] == `SRR_ROT_OPC);
    end
  endfunction

  // ------------------------------------------------------------
  // Operand address
  // ------------------------------------------------------------
  // Bank and offset resolution for a file operand
  function [11:0] file_addr;
    input [15:0] w;
    input [3:0]  bank;
    input        ext;
    input [7:0]  base;
    reg   [7:0]  f;
    reg   [8:0]  sum;
    begin
      f   = w[`SRR_FADDR_HI:`SRR_FADDR_LO];
      sum = {1'b0, base} + {1'b0, f};
      if (w[`SRR_ACC_BIT]) begin
        file_addr = {bank, f};
      end else if (ext && (f <= `SRR_LOW_BANK_LIM)) begin
        // Index wraps within the first page; the carry is dropped on purpose
        file_addr = {`SRR_ACC_LO_BANK, sum[7:0]};
      end else if (f <= `SRR_LOW_BANK_LIM) begin
        // Access bank: low part from page zero, high part from the top page
        file_addr = {`SRR_ACC_LO_BANK, f};
      end else begin
        file_addr = {`SRR_ACC_HI_BANK, f};
      end
    end
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_RET2 = 1'b1;

  reg        state_reg;
  reg        state_next;
  reg [11:0] rd_addr_next;
  reg [11:0] wr_addr_next;
  reg [7:0]  wdata_next;
  reg        we_next;
  reg        pop_next;
  reg        pc_load_next;
  reg [PC_W-1:0] pc_next;
  reg [7:0]  w_next;
  reg [7:0]  st_next;
  reg [3:0]  bsr_next;
  reg [7:0]  rot_res;
  reg        busy_next;

  // ------------------------------------------------------------
  // Decoded strobes and fields
  // ------------------------------------------------------------
  // A word offered in the second return cycle is dropped, not queued
  wire        ret_hit  = instr_valid_i && (state_reg == ST_IDLE) && is_ret(instr_i);
  wire        rot_hit  = instr_valid_i && (state_reg == ST_IDLE) && is_rot(instr_i);
  wire        fast_sel = instr_i[`SRR_FAST_BIT];
  wire        dest_sel = instr_i[`SRR_DEST_BIT];
  wire [11:0] cur_addr = file_addr(instr_i, bank_select_reg_o, ext_set_en_i, fsr2_base_i);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always @* begin
    state_next   = ST_IDLE;
    rd_addr_next = cur_addr;
    wr_addr_next = mem_waddr_o;
    wdata_next   = mem_wdata_o;
    we_next      = 1'b0;
    pop_next     = 1'b0;
    pc_load_next = 1'b0;
    pc_next      = pc_o;
    w_next       = working_reg_o;
    st_next      = flag_reg_o;
    bsr_next     = bank_select_reg_o;
    busy_next    = 1'b0;
    // Memory answers the read of this cycle, so rotate in one cycle
    rot_res = {mem_rdata_i[6:0], flag_reg_o[`SRR_FLAG_C]};
    case (state_reg)
      ST_IDLE: begin
        if (ret_hit) begin
          // Only the counter moves; pc_high_latch and pc_upper_latch hold
          pop_next     = 1'b1;
          pc_load_next = 1'b1;
          pc_next      = stack_top_value_i;
          state_next   = ST_RET2;
          busy_next    = 1'b1;
          if (fast_sel) begin
            w_next   = shadow_working_reg_i;
            st_next  = shadow_flag_reg_i;
            bsr_next = shadow_bank_select_i;
          end
          // Fast bit clear: registers keep their values
        end else if (rot_hit) begin
          // Flags outside C, N and Z keep their value
          st_next[`SRR_FLAG_C] = mem_rdata_i[7];
          st_next[`SRR_FLAG_N] = rot_res[7];
          st_next[`SRR_FLAG_Z] = (rot_res == `SRR_RST_BYTE);
          if (dest_sel) begin
            wr_addr_next = cur_addr;
            wdata_next   = rot_res;
            we_next      = 1'b1;
          end else begin
            w_next = rot_res;
          end
        end
      end
      ST_RET2: begin
        // Second cycle of the return is a flushed fetch slot
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  // Pulses last one cycle; busy_o marks the flushed fetch slot
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg   <= ST_IDLE;
      mem_we_o    <= 1'b0;
      stack_pop_o <= 1'b0;
      pc_load_o   <= 1'b0;
      busy_o      <= 1'b0;
    end else begin
      state_reg   <= state_next;
      mem_we_o    <= we_next;
      stack_pop_o <= pop_next;
      pc_load_o   <= pc_load_next;
      busy_o      <= busy_next;
    end
  end

  // ------------------------------------------------------------
  // Datapath and core registers
  // ------------------------------------------------------------
  // Write lands one cycle after its read, so memory must forward it
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mem_raddr_o       <= `SRR_RST_ADDR;
      mem_waddr_o       <= `SRR_RST_ADDR;
      mem_wdata_o       <= `SRR_RST_BYTE;
      pc_o              <= `SRR_RST_PC;
      working_reg_o     <= `SRR_RST_BYTE;
      flag_reg_o        <= `SRR_RST_BYTE;
      bank_select_reg_o <= `SRR_RST_BANK;
    end else begin
      mem_raddr_o       <= rd_addr_next;
      mem_waddr_o       <= wr_addr_next;
      mem_wdata_o       <= wdata_next;
      pc_o              <= pc_next;
      working_reg_o     <= w_next;
      flag_reg_o        <= st_next;
      bank_select_reg_o <= bsr_next;
    end
  end

endmodule // srr_exec

// [design/srr_exec_map.vh]
/*
  Constants for the return / rotate execution block: opcode patterns,
  field positions, flag bit positions, address limits and reset values.
  Assumes a 16-bit instruction word and an 8-bit data path.
*/
`ifndef SRR_EXEC_MAP_VH
`define SRR_EXEC_MAP_VH

// ------------------------------------------------------------
// Opcode patterns
// ------------------------------------------------------------
`define SRR_RET_OPC       16'h0012
`define SRR_RET_MASK      16'hfffe
`define SRR_ROT_OPC       6'h0d
`define SRR_ROT_OPC_HI    15
`define SRR_ROT_OPC_LO    10

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SRR_FAST_BIT      0
`define SRR_DEST_BIT      9
`define SRR_ACC_BIT       8
`define SRR_FADDR_HI      7
`define SRR_FADDR_LO      0

// ------------------------------------------------------------
// Flag positions in the status register
// ------------------------------------------------------------
`define SRR_FLAG_C        0
`define SRR_FLAG_Z        2
`define SRR_FLAG_N        4

// ------------------------------------------------------------
// Addressing limits and reset values
// ------------------------------------------------------------
`define SRR_LOW_BANK_LIM  8'h5f
`define SRR_ACC_HI_BANK   4'hf
`define SRR_ACC_LO_BANK   4'h0
`define SRR_RST_BYTE      8'h00
`define SRR_RST_BANK      4'h0
`define SRR_RST_ADDR      12'h000
`define SRR_RST_PC        21'h00_0000

`endif

// [verif/srr_exec_properties.sv]
/* Port checker for srr_exec.
   Assumes the bound instance uses the map header and one clock domain. */
`include "srr_exec_map.vh"
module srr_exec_props #(parameter PC_W = 21) (
  input wire logic            sys_clk_i, rst_n_i, instr_valid_i, busy_o,
  input wire logic            mem_we_o, stack_pop_o, pc_load_o, ext_set_en_i,
  input wire logic [15:0]     instr_i,
  input wire logic [PC_W-1:0] stack_top_value_i, pc_o,
  input wire logic [7:0]      shadow_working_reg_i, shadow_flag_reg_i, fsr2_base_i, mem_rdata_i, mem_wdata_o,
  input wire logic [7:0]      working_reg_o, flag_reg_o,
  input wire logic [3:0]      shadow_bank_select_i, bank_select_reg_o,
  input wire logic [11:0]     mem_waddr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire       take   = instr_valid_i && !busy_o;
  wire       is_ret = take && (instr_i & `SRR_RET_MASK) == `SRR_RET_OPC;
  wire [7:0] res    = {mem_rdata_i[6:0], flag_reg_o[0]};
  sequence ret_s(s); is_ret && instr_i[0] == s; endsequence
  sequence rot_s; take && instr_i[15:10] == `SRR_ROT_OPC; endsequence
  sequence ret_done_s; stack_pop_o && pc_load_o && busy_o ##1 !busy_o && !stack_pop_o && !pc_load_o; endsequence
  ret_pop_a: assert property (is_ret |=> pc_o == $past(stack_top_value_i) ##0 ret_done_s)
    else $error("return pop wrong");
  fast_ret_a: assert property (ret_s(1'b1) |=> working_reg_o == $past(shadow_working_reg_i)
    && flag_reg_o == $past(shadow_flag_reg_i)
    && bank_select_reg_o == $past(shadow_bank_select_i)) else $error("no restore");
  slow_ret_a: assert property (ret_s(1'b0) |=> $stable(working_reg_o) && $stable(flag_reg_o)
    && $stable(bank_select_reg_o)) else $error("registers changed");
  rot_flag_a: assert property (rot_s |=> flag_reg_o[0] == $past(mem_rdata_i[7])
    && flag_reg_o[4] == $past(res[7])
    && flag_reg_o[2] == ($past(res) == 8'h00)) else $error("rotate flags wrong");
  rot_file_a: assert property (rot_s ##0 instr_i[9] |=> mem_we_o && mem_wdata_o == $past(res))
    else $error("file result wrong");
  rot_work_a: assert property (rot_s ##0 !instr_i[9] |=> !mem_we_o && working_reg_o == $past(res))
    else $error("working result wrong");
  bank_addr_a: assert property (rot_s ##0 instr_i[9:8] == 2'b11 |=>
    mem_waddr_o == {$past(bank_select_reg_o), $past(instr_i[7:0])}) else $error("bank address wrong");
  index_addr_a: assert property (rot_s ##0 instr_i[9:8] == 2'b10 && ext_set_en_i
    && instr_i[7:0] <= `SRR_LOW_BANK_LIM |=> mem_waddr_o[11:8] == 4'h0
    && mem_waddr_o[7:0] == 8'($past(fsr2_base_i) + $past(instr_i[7:0]))) else $error("index wrong");
endmodule // srr_exec_props
bind srr_exec srr_exec_props #(.PC_W(PC_W)) u_props (.*);

// [verif/srr_mem_model.sv]
/* Data memory beside srr_exec: combinational read, clocked write.
   Assumes the bank input is the core's live bank-select value. */
module srr_mem_model (
  input  wire logic        clk_i, we_i, ext_i,
  input  wire logic [15:0] instr_i,
  input  wire logic [3:0]  bank_i,
  input  wire logic [7:0]  base_i, wdata_i,
  input  wire logic [11:0] waddr_i,
  output logic      [11:0] addr_o,
  output logic      [7:0]  rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ram [0:4095];
  wire  [7:0] f = instr_i[7:0];
  initial for (int i = 0; i < 4096; i++) ram[i] = 8'(i * 37);
  always_comb begin
    if (instr_i[8]) addr_o = {bank_i, f};
    else if (ext_i && f <= 8'h5f) addr_o = {4'h0, base_i + f};
    else addr_o = {(f > 8'h5f) ? 4'hf : 4'h0, f};
    // Bypass so a write still in flight is seen by the next read
    rdata_o = (we_i && waddr_i == addr_o) ? wdata_i : ram[addr_o];
  end
  always @(posedge clk_i) if (we_i) ram[waddr_i] <= wdata_i;
endmodule // srr_mem_model

// [verif/tb.sv]
/* Random bench for srr_exec with a data memory model.
   Assumes one instruction per cycle and a gap cycle after each return. */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_i = 0, rst_n_i = 0, instr_valid_i = 0, ext_set_en_i = 0;
  logic [15:0] instr_i = 16'h0000;
  logic [20:0] stack_top_value_i = 21'h0;
  logic [7:0]  shadow_working_reg_i = 0, shadow_flag_reg_i = 0, fsr2_base_i = 0, w = 0, fl = 0, r;
  logic [3:0]  shadow_bank_select_i = 0, bank_select_reg = 0;
  logic [31:0] rv;
  logic [41:0] n;
  logic [41:0] notes [$];
  wire  [7:0]  mem_rdata_i, mem_wdata_o, working_reg_o, flag_reg_o;
  wire  [11:0] mem_raddr_o, mem_waddr_o, addr;
  wire  [20:0] pc_o;
  wire  [3:0]  bank_select_reg_o;
  wire         mem_we_o, stack_pop_o, pc_load_o, busy_o;
  int          err_total = 0, num_checks = 0, seed = 12124, cyc = 0;
  srr_exec dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .ext_set_en_i(ext_set_en_i), .stack_top_value_i(stack_top_value_i),
    .shadow_working_reg_i(shadow_working_reg_i), .shadow_flag_reg_i(shadow_flag_reg_i),
    .shadow_bank_select_i(shadow_bank_select_i), .fsr2_base_i(fsr2_base_i), .mem_rdata_i(mem_rdata_i),
    .mem_raddr_o(mem_raddr_o), .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o),
    .stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o), .pc_o(pc_o), .working_reg_o(working_reg_o),
    .flag_reg_o(flag_reg_o), .bank_select_reg_o(bank_select_reg_o), .busy_o(busy_o));
  srr_mem_model mem (.clk_i(sys_clk_i), .we_i(mem_we_o), .ext_i(ext_set_en_i), .instr_i(instr_i),
    .bank_i(bank_select_reg_o), .base_i(fsr2_base_i), .wdata_i(mem_wdata_o), .waddr_i(mem_waddr_o),
    .addr_o(addr), .rdata_o(mem_rdata_i));
  always #10 sys_clk_i = ~sys_clk_i;
  task automatic report(input logic [40:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_ret(input logic [40:0] e);
    report(e, {pc_o, working_reg_o, flag_reg_o, bank_select_reg_o});
  endtask
  task automatic cmp_rot(input logic [40:0] e);
    report(e, {4'h0, mem_we_o, mem_raddr_o,
      mem_we_o ? mem_wdata_o : 8'h00, working_reg_o, flag_reg_o});
    if (e[36]) report({29'h0, e[35:24]}, {29'h0, mem_waddr_o});
  endtask
  task final_report;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Watcher and timeout
  // ------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      final_report;
    end else begin
      #1;
      if (notes.size() > 0) begin
        n = notes.pop_front();
        if (n[41]) cmp_ret(n[40:0]);
        else cmp_rot(n[40:0]);
      end
    end
  end
  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk_i);
    @(negedge sys_clk_i) rst_n_i = 1;
    repeat (400) begin
      @(negedge sys_clk_i);
      rv = $random(seed);
      {stack_top_value_i, shadow_working_reg_i, shadow_flag_reg_i} = 37'({$random(seed), $random(seed)});
      {shadow_bank_select_i, fsr2_base_i, ext_set_en_i} = 13'($random(seed));
      instr_valid_i = 1;
      if (rv[31]) begin
        instr_i = {15'h0009, rv[0]};
        if (rv[0]) {w, fl, bank_select_reg} = {shadow_working_reg_i, shadow_flag_reg_i, shadow_bank_select_i};
        notes.push_back({1'b1, stack_top_value_i, w, fl, bank_select_reg});
        // Offered in the busy cycle, must be dropped
        @(negedge sys_clk_i) instr_i = 16'h37ff;
      end else begin
        instr_i = {6'h0d, rv[9:0]};
        #1 r = {mem_rdata_i[6:0], fl[0]};
        fl = {fl[7:5], r[7], fl[3], r == 8'h00, fl[1], mem_rdata_i[7]};
        if (!rv[9]) w = r;
        notes.push_back({1'b0, 4'h0, rv[9], addr, rv[9] ? r : 8'h00, w, fl});
      end
    end
    @(negedge sys_clk_i) instr_valid_i = 0;
    repeat (3) @(negedge sys_clk_i);
    final_report;
  end
endmodule // tb
